// >>> include/awce_pkg.sv
// constants and carriers for the ata write command engine
package awce_pkg;
  // apb register byte offsets
  localparam logic [7:0] A_DATA = 8'h00;
  localparam logic [7:0] A_FEAT = 8'h04;
  localparam logic [7:0] A_CNT = 8'h08;
  localparam logic [7:0] A_LO = 8'h0C;
  localparam logic [7:0] A_MID = 8'h10;
  localparam logic [7:0] A_HI = 8'h14;
  localparam logic [7:0] A_DEV = 8'h18;
  localparam logic [7:0] A_CMD = 8'h1C;
  localparam logic [7:0] A_CTL = 8'h20;
  localparam logic [7:0] A_ERR = 8'h24;
  localparam logic [7:0] A_MCFG = 8'h28;
  localparam logic [7:0] A_IDENT = 8'h2C;
  localparam logic [7:0] A_TAG = 8'h30;
  // opcodes
  localparam logic [7:0] CMD_FPDMA_WR = 8'h61;
  localparam logic [7:0] CMD_WR_MULT = 8'hC5;
  localparam logic [7:0] CMD_WR_MULT_EXT = 8'h39;
  // field positions
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABRT = 2;
  localparam int ER_MEDIA = 6;
  localparam int DEV_FUA = 7;
  localparam int DEV_LBA = 6;
  localparam int CTL_HOB = 7;
  localparam int MCFG_EN = 8;
  localparam int TAG_LSB = 3;
  // reset values and counts
  localparam logic [15:0] TF_RST = 16'h0000;
  localparam logic [7:0] DEV_RST = 8'hA0;
  localparam logic [16:0] CNT_MAX = 17'h1_0000;
  localparam logic [16:0] CNT28_MAX = 17'h0_0100;
  // busy must rise this soon after the opcode
  localparam int BUSY_NS = 400;
  localparam int CLK_NS = 25;
  localparam int BUSY_CYC = BUSY_NS / CLK_NS;
  // request to the flash back end
  typedef struct packed {
    logic wr;
    logic fua;
    logic [47:0] lba;
  } awce_mreq_t;
  // one data word toward the sector buffer
  typedef struct packed {
    logic we;
    logic [15:0] data;
  } awce_word_t;
endpackage

// >>> hw/awce_engine.sv
// write command engine: task file, apb slave, block sequencing
// Function
// - with queuing enabled, accept queued write opcode and take host data
// - forced-unit-access one: commit to media before completion
// - forced-unit-access zero: completion may precede media commit
// - queued length comes from features; zero means 65536 sectors
// - busy rises within 400 ns of a multiple write opcode
// - multiple write interrupts once per block, not per sector
// - data request qualified only at each block start
// - multiple write count is sectors, not blocks
// - uneven count gives full blocks then one partial block
// - abort multiple write if block size unset or multiple disabled
// - error posted after block attempt; stop at failing sector
// - interrupt whenever data request rises at a multiple write block start
// - on error load failing address and residual sector count
// - block sizes up to MAX_BLK supported (one by default); reported in identify data
// - extended multiple write uses 48-bit address, 16-bit count
// - high-order-byte bit selects upper half; any task file access clears it
// - extended error reports 48-bit address and 16-bit residual
// - on accept raise busy, then data request with busy low
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module awce_engine #(
  parameter int SECTOR_WORDS = 256,
  parameter logic [7:0] MAX_BLK = 8'h01,
  parameter bit NCQ_EN = 1'b1
) (
  // clock, reset, enable
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // host interrupt
  output logic INTRQ,
  // flash back end
  output awce_pkg::awce_mreq_t MEDIA_REQ,
  output awce_pkg::awce_word_t MEDIA_WORD,
  input wire logic MEDIA_ACK,
  input wire logic MEDIA_ERR
);
  import awce_pkg::*;
  typedef enum logic [2:0] {
    S_IDLE, S_BUSY, S_DRQ, S_COMMIT, S_WAIT
  } awce_state_t;
  localparam int WW = $clog2(SECTOR_WORDS);
  localparam logic [WW-1:0] LAST_W = WW'(SECTOR_WORDS - 1);
  awce_state_t st_q;
  logic [15:0] feat_q, cnt_q, lo_q, mid_q, hi_q;
  logic [7:0] dev_q, err_q, mblk_q;
  logic men_q, hob_q, bsy_q, drq_q, errst_q, intrq_q, pready_q;
  logic [47:0] lba_q;
  logic [16:0] rem_q;
  logic [7:0] bs_q, rx_q, cm_q;
  logic [WW-1:0] word_q;
  logic fua_q, blkint_q;
  logic [4:0] tag_q;
  awce_mreq_t mreq_q;
  awce_word_t mword_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  // byte lane select for one half of a 16-bit task file field
  function automatic logic [15:0] put_half(input logic [15:0] r,
      input logic hob, input logic [7:0] b);
    put_half = hob ? {b, r[7:0]} : {r[15:8], b};
  endfunction
  function automatic logic [7:0] get_half(input logic [15:0] r,
      input logic hob);
    get_half = hob ? r[15:8] : r[7:0];
  endfunction
  function automatic logic [16:0] len16(input logic [15:0] v);
    len16 = (v == 16'h0000) ? CNT_MAX : {1'b0, v};
  endfunction
  // apb: answer comes one cycle into the access phase
  logic acc, done, wr_go, rd_go, tf_hit;
  assign acc = PSEL & PENABLE & ~pready_q;
  assign done = PSEL & PENABLE & pready_q;
  assign wr_go = done & PWRITE;
  assign rd_go = done & ~PWRITE;
  assign tf_hit = (PADDR <= A_CMD) && (PADDR[1:0] == 2'b00);
  // opcode decode
  logic cmd_go, is_q, is_m, is_x, mult_ok, good;
  logic [47:0] lba_in;
  logic [16:0] len_in;
  logic [7:0] cmd;
  assign cmd = PWDATA[7:0];
  assign cmd_go = wr_go && (PADDR == A_CMD) && (st_q == S_IDLE);
  assign is_q = NCQ_EN && (cmd == CMD_FPDMA_WR);
  assign is_m = (cmd == CMD_WR_MULT) && dev_q[DEV_LBA];
  assign is_x = (cmd == CMD_WR_MULT_EXT);
  // size zero or above the supported limit counts as never set
  assign mult_ok = men_q && (mblk_q != 8'h00) &&
                   (mblk_q <= MAX_BLK);
  assign good = is_q | ((is_m | is_x) & mult_ok);
  // 28-bit form packs head, cylinder and sector fields
  assign lba_in = is_m ?
      {20'h0_0000, dev_q[3:0], hi_q[7:0], mid_q[7:0], lo_q[7:0]} :
      {hi_q[15:8], mid_q[15:8], lo_q[15:8],
       hi_q[7:0], mid_q[7:0], lo_q[7:0]};
  // 28-bit count of zero means 256 sectors
  assign len_in = is_q ? len16(feat_q) :
      is_x ? len16(cnt_q) :
      ((cnt_q[7:0] == 8'h00) ? CNT28_MAX : {9'h000, cnt_q[7:0]});
  // block length: full block or the remainder
  logic [7:0] blk_len;
  assign blk_len = (rem_q < {9'h000, bs_q}) ? rem_q[7:0] : bs_q;
  logic data_wr, last_word, fail, ok_ack, stat_rd;
  assign data_wr = wr_go && (PADDR == A_DATA) && (st_q == S_DRQ);
  assign last_word = (word_q == LAST_W);
  assign fail = (st_q == S_WAIT) && MEDIA_ACK && MEDIA_ERR;
  assign ok_ack = (st_q == S_WAIT) && MEDIA_ACK && !MEDIA_ERR;
  assign stat_rd = rd_go && (PADDR == A_CMD);
  // apb handshake and read data
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (CE) begin
      pready_q <= acc;
      pslverr_q <= 1'b0;
      if (acc) begin
        prdata_q <= 32'h0000_0000;
        case (PADDR)
          A_FEAT: prdata_q[7:0] <= get_half(feat_q, hob_q);
          A_CNT: prdata_q[7:0] <= get_half(cnt_q, hob_q);
          A_LO: prdata_q[7:0] <= get_half(lo_q, hob_q);
          A_MID: prdata_q[7:0] <= get_half(mid_q, hob_q);
          A_HI: prdata_q[7:0] <= get_half(hi_q, hob_q);
          A_DEV: prdata_q[7:0] <= dev_q;
          A_CMD: prdata_q[7:0] <= {bsy_q, ~bsy_q, 2'b00, drq_q,
                                   2'b00, errst_q};
          A_CTL: prdata_q[CTL_HOB] <= hob_q;
          A_ERR: prdata_q[7:0] <= err_q;
          A_MCFG: prdata_q[8:0] <= {men_q, mblk_q};
          A_IDENT: prdata_q[7:0] <= MAX_BLK;
          A_TAG: prdata_q[4:0] <= tag_q;
          A_DATA: prdata_q <= 32'h0000_0000;
          default: pslverr_q <= 1'b1; // unmapped
        endcase
      end
    end
  end
  // high-order-byte select: set by control, cleared by task file access
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      hob_q <= 1'b0;
    end else if (CE) begin
      if (wr_go && (PADDR == A_CTL)) begin
        hob_q <= PWDATA[CTL_HOB];
      end else if (done && tf_hit) begin
        hob_q <= 1'b0;
      end
    end
  end
  // multiple-mode setting, written by the set-multiple path
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      mblk_q <= 8'h00;
      men_q <= 1'b0;
    end else if (CE && wr_go && (PADDR == A_MCFG) && st_q == S_IDLE) begin
      mblk_q <= PWDATA[7:0];
      men_q <= PWDATA[MCFG_EN];
    end
  end
  // task file: host writes while idle, error report overrides
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      feat_q <= TF_RST;
      cnt_q <= TF_RST;
      lo_q <= TF_RST;
      mid_q <= TF_RST;
      hi_q <= TF_RST;
      dev_q <= DEV_RST;
    end else if (CE) begin
      if (fail) begin
        // failing sector and the residual including it
        lo_q <= {lba_q[31:24], lba_q[7:0]};
        mid_q <= {lba_q[39:32], lba_q[15:8]};
        hi_q <= {lba_q[47:40], lba_q[23:16]};
        cnt_q <= rem_q[15:0];
        dev_q[3:0] <= lba_q[27:24];
      end else if (wr_go && st_q == S_IDLE) begin
        case (PADDR)
          A_FEAT: feat_q <= put_half(feat_q, hob_q, PWDATA[7:0]);
          A_CNT: cnt_q <= put_half(cnt_q, hob_q, PWDATA[7:0]);
          A_LO: lo_q <= put_half(lo_q, hob_q, PWDATA[7:0]);
          A_MID: mid_q <= put_half(mid_q, hob_q, PWDATA[7:0]);
          A_HI: hi_q <= put_half(hi_q, hob_q, PWDATA[7:0]);
          A_DEV: dev_q <= PWDATA[7:0];
          default: dev_q <= dev_q;
        endcase
      end
    end
  end
  // command sequencer
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st_q <= S_IDLE;
      bsy_q <= 1'b0;
      drq_q <= 1'b0;
      errst_q <= 1'b0;
      err_q <= 8'h00;
      lba_q <= 48'h0000_0000_0000;
      rem_q <= 17'h0_0000;
      bs_q <= 8'h01;
      rx_q <= 8'h00;
      cm_q <= 8'h00;
      word_q <= '0;
      fua_q <= 1'b0;
      blkint_q <= 1'b0;
      tag_q <= 5'h00;
    end else if (CE) begin
      case (st_q)
        S_IDLE: begin
          if (cmd_go) begin
            errst_q <= ~good;
            err_q <= good ? 8'h00 : 8'h04;
            if (good) begin
              bsy_q <= 1'b1;
              st_q <= S_BUSY;
              lba_q <= lba_in;
              rem_q <= len_in;
              bs_q <= is_q ? 8'h01 : mblk_q;
              blkint_q <= ~is_q;
              fua_q <= is_q & dev_q[DEV_FUA];
              tag_q <= is_q ? cnt_q[TAG_LSB+4:TAG_LSB] : tag_q;
            end
          end
        end
        S_BUSY: begin
          // block start: only here is data request qualified
          bsy_q <= 1'b0;
          drq_q <= 1'b1;
          rx_q <= blk_len;
          cm_q <= blk_len;
          word_q <= '0;
          st_q <= S_DRQ;
        end
        S_DRQ: begin
          if (data_wr) begin
            word_q <= last_word ? '0 : word_q + 1'b1;
            if (last_word) begin
              rx_q <= rx_q - 8'h01;
              if (rx_q == 8'h01) begin
                drq_q <= 1'b0;
                bsy_q <= 1'b1;
                st_q <= S_COMMIT;
              end
            end
          end
        end
        S_COMMIT: st_q <= S_WAIT;
        S_WAIT: begin
          if (fail) begin
            // later blocks of the command are dropped
            bsy_q <= 1'b0;
            errst_q <= 1'b1;
            err_q <= 8'h40;
            st_q <= S_IDLE;
          end else if (ok_ack) begin
            lba_q <= lba_q + 48'h0000_0000_0001;
            rem_q <= rem_q - 17'h0_0001;
            cm_q <= cm_q - 8'h01;
            if (rem_q == 17'h0_0001) begin
              bsy_q <= 1'b0;
              st_q <= S_IDLE;
            end else if (cm_q == 8'h01) begin
              st_q <= S_BUSY;
            end else begin
              st_q <= S_COMMIT;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // interrupt: multiple write block starts, completion, error; a status read clears it
  logic int_set;
  assign int_set = (st_q == S_BUSY && blkint_q) || fail ||
      (ok_ack && rem_q == 17'h0_0001) || (cmd_go && !good);
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      intrq_q <= 1'b0;
    end else if (CE) begin
      if (int_set) begin
        intrq_q <= 1'b1;
      end else if (stat_rd) begin
        intrq_q <= 1'b0;
      end
    end
  end
  // back end strobes; fua travels with each commit request
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      mreq_q <= '0;
      mword_q <= '0;
    end else if (CE) begin
      mreq_q.wr <= (st_q == S_COMMIT);
      mreq_q.fua <= fua_q;
      mreq_q.lba <= lba_q;
      mword_q.we <= data_wr;
      mword_q.data <= PWDATA[15:0];
    end
  end
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign INTRQ = intrq_q;
  assign MEDIA_REQ = mreq_q;
  assign MEDIA_WORD = mword_q;
  // checks; busy bound is the 400 ns limit in whole clock cycles
  localparam int BUSY_LIM = BUSY_CYC;
  a_busy_rise: assert property (@(posedge MCLK) disable iff (SYS_RST)
    cmd_go && CE && good |-> ##[1:BUSY_LIM] bsy_q)
    else $error("busy late after opcode");
  a_abort_nomult: assert property (@(posedge MCLK) disable iff (SYS_RST)
    cmd_go && CE && (is_m | is_x) && !mult_ok && !is_q
    |=> errst_q && err_q[ER_ABRT] && st_q == S_IDLE)
    else $error("multiple write not aborted");
  a_drq_block: assert property (@(posedge MCLK) disable iff (SYS_RST)
    st_q == S_DRQ && !(data_wr && last_word && rx_q == 8'h01)
    |=> drq_q && st_q == S_DRQ)
    else $error("data request dropped inside block");
  a_intr_block: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CE && st_q == S_BUSY && blkint_q |=> drq_q && intrq_q)
    else $error("no interrupt at block start");
  a_hob_clear: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CE && done && tf_hit |=> !hob_q)
    else $error("high byte select not cleared");
  a_residual: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CE && fail |=> cnt_q == $past(rem_q[15:0]) &&
    lo_q[7:0] == $past(lba_q[7:0]))
    else $error("error residual wrong");
  a_queue_len: assert property (@(posedge MCLK) disable iff (SYS_RST)
    cmd_go && CE && is_q && feat_q == 16'h0000
    |=> rem_q == CNT_MAX)
    else $error("zero queued length not 65536");
  a_tag_keep: assert property (@(posedge MCLK) disable iff (SYS_RST)
    cmd_go && CE && is_q |=> tag_q == $past(cnt_q[7:3]))
    else $error("queued tag not stored");
  a_fua_commit: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CE && st_q == S_WAIT && !MEDIA_ACK |=> st_q == S_WAIT)
    else $error("completion reported before media commit");
  a_block_limit: assert property (@(posedge MCLK) disable iff (SYS_RST)
    st_q == S_DRQ |-> rx_q <= MAX_BLK)
    else $error("block larger than supported");
  c_mult_done: cover property (@(posedge MCLK) disable iff (SYS_RST)
    st_q == S_WAIT && ok_ack && rem_q == 17'h0_0001 && blkint_q);
  c_queued: cover property (@(posedge MCLK) disable iff (SYS_RST)
    cmd_go && is_q && dev_q[DEV_FUA]);
  c_media_fail: cover property (@(posedge MCLK) disable iff (SYS_RST)
    fail);
  c_abort: cover property (@(posedge MCLK) disable iff (SYS_RST)
    cmd_go && !good);
endmodule

// >>> sim/awce_media_model.sv
// behavioural flash back end answering sector commits
`timescale 1ns/1ps
module awce_media_model (
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // commit request from the engine
  input awce_pkg::awce_mreq_t MEDIA_REQ,
  // failure injection from the bench
  input wire logic fail_en,
  input wire logic [47:0] fail_lba,
  // commit answer
  output logic MEDIA_ACK,
  output logic MEDIA_ERR
);
  import awce_pkg::*;
  logic [3:0] wait_q;
  logic bad_q;
  logic slow_q;
  // answers alternate prompt and slow so the engine cannot count on timing;
  // the error line toggles when not qualified so stale values never match
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      wait_q <= 4'h0;
      bad_q <= 1'b0;
      slow_q <= 1'b0;
      MEDIA_ACK <= 1'b0;
      MEDIA_ERR <= 1'b0;
    end else begin
      MEDIA_ACK <= 1'b0;
      MEDIA_ERR <= ~MEDIA_ERR;
      if (MEDIA_REQ.wr) begin
        wait_q <= slow_q ? 4'h6 : 4'h1;
        slow_q <= ~slow_q;
        bad_q <= fail_en && (MEDIA_REQ.lba == fail_lba);
      end else if (wait_q == 4'h1) begin
        MEDIA_ACK <= 1'b1;
        MEDIA_ERR <= bad_q;
        wait_q <= 4'h0;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule

// >>> sim/ata_write_command_engine_tb.sv
// self-checking bench for the write command engine over apb
`timescale 1ns/1ps
module ata_write_command_engine_tb;
  import awce_pkg::*;
  localparam int SW = 4;
  localparam logic [7:0] MAXB = 8'h02;
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic CE = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, INTRQ, MEDIA_ACK, MEDIA_ERR;
  awce_mreq_t MEDIA_REQ;
  awce_word_t MEDIA_WORD;
  logic fail_en = 1'b0;
  logic [47:0] fail_lba = 48'h0000_0000_0000;
  int n_errors = 0;
  int check_count = 0;
  int n_irq = 0, n_com = 0, n_wd = 0;
  logic irq_d = 1'b0;
  logic clr_req = 1'b0;
  int n_bdw = 0;
  logic fua_seen;
  logic [47:0] lba_first;
  logic [47:0] r;
  logic e;
  logic [40:0] rows [8];

  always #12.5 MCLK = ~MCLK;

  awce_engine #(.SECTOR_WORDS(SW), .MAX_BLK(MAXB), .NCQ_EN(1'b1)) u_dut (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .INTRQ(INTRQ),
    .MEDIA_REQ(MEDIA_REQ), .MEDIA_WORD(MEDIA_WORD),
    .MEDIA_ACK(MEDIA_ACK), .MEDIA_ERR(MEDIA_ERR));

  awce_media_model u_media (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .MEDIA_REQ(MEDIA_REQ), .fail_en(fail_en), .fail_lba(fail_lba),
    .MEDIA_ACK(MEDIA_ACK), .MEDIA_ERR(MEDIA_ERR));

  // interrupt rises, commits and data words seen at the ports
  always @(posedge MCLK) begin
    irq_d <= INTRQ;
    if (INTRQ === 1'b1 && irq_d !== 1'b1) n_irq <= n_irq + 1;
    if (MEDIA_REQ.wr === 1'b1) begin
      if (n_com == 0) lba_first <= MEDIA_REQ.lba;
      fua_seen <= MEDIA_REQ.fua;
      n_com <= n_com + 1;
    end
    if (MEDIA_WORD.we === 1'b1) n_wd <= n_wd + 1;
    if (MEDIA_WORD.we === 1'b1 && MEDIA_WORD.data !== 16'h5A5A)
      n_bdw <= n_bdw + 1;
    // a clear request wins over the interrupt, commit and word counts of the same cycle
    if (clr_req) begin
      n_irq <= 0;
      n_com <= 0;
      n_wd <= 0;
    end
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one apb transfer; entered just after a rising edge, idles one cycle
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 64);
    r = 48'(PRDATA);
    e = PSLVERR;
    if (n >= 64) n_errors++;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // upper byte under the high-order bit, then lower byte with it cleared
  task automatic hob(input logic [7:0] a, input logic [7:0] u,
                     input logic [7:0] l);
    wr(A_CTL, 32'h0000_0080);
    wr(a, {24'h00_0000, u});
    wr(a, {24'h00_0000, l});
  endtask

  // status polling also clears a pending interrupt
  task automatic poll;
    int n;
    n = 0;
    do begin
      rd(A_CMD);
      n++;
    end while (r[ST_BSY] !== 1'b0 && n < 100);
  endtask

  // host side of a sector flow: whole block per data request
  task automatic xfer(input int nsec, input int bs);
    int rem;
    int k;
    rem = nsec;
    while (rem > 0) begin
      poll();
      if (r[ST_DRQ] !== 1'b1) return;
      k = (rem < bs) ? rem : bs;
      repeat (k * SW) wr(A_DATA, 32'h0000_5A5A);
      rem -= k;
    end
    poll();
  endtask

  // counters clear at the next edge, so the monitor stays their one driver
  task automatic clr;
    clr_req <= 1'b1;
    @(posedge MCLK);
    clr_req <= 1'b0;
  endtask

  initial begin
    rows[0] = {A_CMD, 32'h0000_0040, 1'b0};
    rows[1] = {A_DEV, 32'h0000_00A0, 1'b0};
    rows[2] = {A_CNT, 32'h0000_0000, 1'b0};
    rows[3] = {A_MCFG, 32'h0000_0000, 1'b0};
    rows[4] = {A_IDENT, {24'h00_0000, MAXB}, 1'b0};
    rows[5] = {A_TAG, 32'h0000_0000, 1'b0};
    rows[6] = {A_ERR, 32'h0000_0000, 1'b0};
    rows[7] = {8'h40, 32'h0000_0000, 1'b1};
    repeat (5) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(posedge MCLK);
    // reset values, block size limit and the unmapped slot
    foreach (rows[i]) begin
      rd(rows[i][40:33]);
      chk(r, 48'(rows[i][32:1]));
      chk(48'(e), 48'(rows[i][0]));
    end
    // multiple writes refused: never set, disabled, oversize, no lba bit
    wr(A_DEV, 32'h0000_00E0);
    for (int c = 0; c < 4; c++) begin
      clr();
      if (c == 1) wr(A_MCFG, 32'h0000_0002);
      if (c == 2) wr(A_MCFG, 32'h0000_0103);
      if (c == 3) wr(A_MCFG, 32'h0000_0102);
      if (c == 3) wr(A_DEV, 32'h0000_00A0);
      wr(A_CMD, {24'h00_0000, CMD_WR_MULT});
      poll();
      chk(r, 48'h0041);
      rd(A_ERR);
      chk(r, 48'h0004);
      chk(48'(n_irq), 48'h1);
    end
    // three sectors in blocks of two, then the same with sector two bad
    for (int f = 0; f < 2; f++) begin
      clr();
      fail_en <= f[0];
      fail_lba <= 48'h0000_0A12_3457;
      wr(A_LO, 32'h0000_0056);
      wr(A_MID, 32'h0000_0034);
      wr(A_HI, 32'h0000_0012);
      wr(A_DEV, 32'h0000_00EA);
      wr(A_CNT, 32'h0000_0003);
      wr(A_CMD, {24'h00_0000, CMD_WR_MULT});
      rd(A_CMD);
      chk(r, 48'h0048);
      xfer(3, 2);
      chk(r, f ? 48'h0041 : 48'h0040);
      chk(lba_first, 48'h0000_0A12_3456);
      chk(48'(n_com), f ? 48'h2 : 48'h3);
      chk(48'(n_wd), f ? 48'h8 : 48'hC);
      chk(48'(n_irq), f ? 48'h2 : 48'h3);
      if (f == 1) begin
        rd(A_CNT);
        chk(r, 48'h0002);
        rd(A_LO);
        chk(r, 48'h0057);
        rd(A_DEV);
        chk(r, 48'h00EA);
      end
    end
    // 48-bit address and count through the high-order halves
    clr();
    fail_lba <= 48'h5533_1166_4423;
    hob(A_CNT, 8'h00, 8'h02);
    hob(A_LO, 8'h11, 8'h22);
    hob(A_MID, 8'h33, 8'h44);
    hob(A_HI, 8'h55, 8'h66);
    wr(A_DEV, 32'h0000_0040);
    wr(A_CMD, {24'h00_0000, CMD_WR_MULT_EXT});
    xfer(2, 2);
    chk(r, 48'h0041);
    chk(lba_first, 48'h5533_1166_4422);
    chk(48'(n_com), 48'h2);
    wr(A_CTL, 32'h0000_0080);
    rd(A_LO);
    chk(r, 48'h0011);
    rd(A_LO);
    chk(r, 48'h0023);
    rd(A_CNT);
    chk(r, 48'h0001);
    // queued write with and without forced unit access
    fail_en <= 1'b0;
    for (int f = 0; f < 2; f++) begin
      clr();
      hob(A_FEAT, 8'h00, 8'h01);
      wr(A_CNT, 32'h0000_0028);
      wr(A_DEV, f ? 32'h0000_0040 : 32'h0000_00C0);
      wr(A_CMD, {24'h00_0000, CMD_FPDMA_WR});
      xfer(1, 1);
      chk(r, 48'h0040);
      chk(48'(n_irq), 48'h1);
      chk(48'(n_wd), 48'h4);
      chk(48'(fua_seen), f ? 48'h0 : 48'h1);
      rd(A_TAG);
      chk(r, 48'h0005);
    end
    chk(48'(n_bdw), 48'h0);
    // zero queued length, cut short by a reset in mid-command
    hob(A_FEAT, 8'h00, 8'h00);
    wr(A_CMD, {24'h00_0000, CMD_FPDMA_WR});
    rd(A_CMD);
    chk(r, 48'h0048);
    wr(A_CTL, 32'h0000_0080);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(posedge MCLK);
    rd(A_CTL);
    chk(r, 48'h0000);
    rd(A_CMD);
    chk(r, 48'h0040);
    rd(A_MCFG);
    chk(r, 48'h0000);
    end_sim();
  end

  // watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge MCLK);
    n_errors++;
    end_sim();
  end
endmodule
